// file: verilog/seid_ctrl.sv
// Serial EEPROM command engine: array and identification page read, write and lock.
`timescale 1ns/1ps
`include "seid_defs.svh"
// Function
// - Read: take opcode and address, then shift out the addressed byte.
// - Read continues: address increments after each output byte.
// - Read address wraps from the top of the array to zero.
// - Chip select rising ends a read at any bit.
// - Array read is ignored while a write cycle runs.
// - Write ends on a byte boundary; that edge starts the timed cycle.
// - Write advances only the low address bits within the page.
// - Bytes beyond the page end overwrite from the page start.
// - Write refused without latch, while busy, off boundary or protected.
// - Each timed write erases the bytes, then programs them.
// - Each four-byte group carries a code correcting one bit on read.
// - Partly written groups are rewritten whole to keep the code valid.
// - ID page read uses the six low address bits and increments.
// - ID page read is ignored while a write cycle runs.
// - ID page write uses the six low address bits as position.
// - Lock status byte has bit 0 set when the page is locked.
// - Lock status byte repeats while chip select stays low.
// - Lock needs the latch, region bit one and data bit 1 set.
// - Lock runs only if select rises right after the eighth data bit.
// - Lock discarded if busy, both protect bits set or off boundary.
// - Once locked, the ID page stays locked.
// - The write enable latch clears when a write cycle completes.
// - Busy flag is high exactly while a timed cycle runs.
module seid_ctrl #(
	parameter int TW_CYCLES = `SEID_TW_NS / `SEID_CLK_NS
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic wel_set,
	input  wire logic block_protect_high,
	input  wire logic block_protect_low,
	output logic      miso,
	output logic      miso_oe_n,
	output logic      write_busy_flag,
	output logic      write_enable_latch,
	output logic      id_page_locked
);
	localparam int TMW = $clog2(TW_CYCLES + 1);
	localparam int MD  = `SEID_ARRAY_GROUPS + `SEID_ID_GROUPS;

	logic [2:0]             s1_q;
	logic [2:0]             s2_q;
	logic [2:0]             s3_q;
	seid_pkg::seid_phase_t  ph_q;
	seid_pkg::seid_kind_t   kind_q;
	seid_pkg::seid_kind_t   op_kind;
	logic [2:0]             bit_q;
	logic [6:0]             sr_q;
	logic [15:0]            addr_q;
	logic [1:0]             nb_q;
	logic [7:0]             ldata_q;
	logic                   wp_q;
	seid_pkg::seid_wbyte_t  wb_q;
	logic                   rd_req_q;
	logic                   rd_load_q;
	logic [7:0]             tx_q;
	logic                   miso_q;
	logic                   oe_n_q;
	seid_pkg::seid_cst_t    cst_q;
	logic [3:0]             g_q;
	logic [1:0]             j_q;
	logic [31:0]            grp_q;
	logic                   go_q;
	logic                   busy_q;
	logic [TMW-1:0]         tmr_q;
	logic [8:0]             tpage_q;
	logic                   tid_q;
	logic                   tlock_q;
	logic                   wel_q;
	logic                   lock_q;
	logic [63:0]            fl_q;
	seid_pkg::seid_wbyte_t  fo;
	seid_pkg::seid_group_t  mem_rdata;
	seid_pkg::seid_group_t  mem_wdata;
	logic [7:0]             pb_rdata;
	logic                   f_in_ready;
	logic                   f_ov;
	logic                   f_or;

	// Pin samples after the two-stage synchronisers, and edges seen on them.
	wire sck_rise  = s2_q[0] & ~s3_q[0];
	wire sck_fall  = ~s2_q[0] & s3_q[0];
	wire cs_rise   = s2_q[1] & ~s3_q[1];
	wire sel       = ~s2_q[1];
	wire din       = s2_q[2];
	wire byte_done = sel & sck_rise & (bit_q == 3'h7);
	wire [7:0] rx  = {sr_q, din};

	// Command decode terms.
	wire region   = addr_q[`SEID_REGION_BIT];
	wire in_data  = (ph_q == seid_pkg::PH_DATA);
	wire rd_kind  = (kind_q == seid_pkg::K_READ) | (kind_q == seid_pkg::K_IDR);
	wire lockst   = (kind_q == seid_pkg::K_IDR) & region;
	wire lockcmd  = (kind_q == seid_pkg::K_IDW) & region;
	wire idw      = (kind_q == seid_pkg::K_IDW) & ~region;
	wire adv_arr  = byte_done & in_data & (kind_q == seid_pkg::K_READ);
	wire adv_low  = byte_done & in_data & ((kind_q == seid_pkg::K_WRITE) | idw
		| ((kind_q == seid_pkg::K_IDR) & ~region));
	wire push     = byte_done & in_data & ((kind_q == seid_pkg::K_WRITE) | idw);
	assign op_kind = (rx == `SEID_OP_READ)  ? seid_pkg::K_READ  :
		(rx == `SEID_OP_WRITE) ? seid_pkg::K_WRITE :
		(rx == `SEID_OP_RDID)  ? seid_pkg::K_IDR   :
		(rx == `SEID_OP_WRID)  ? seid_pkg::K_IDW   : seid_pkg::K_NONE;
	wire op_wr    = byte_done & (ph_q == seid_pkg::PH_OP) & ~busy_q
		& ((op_kind == seid_pkg::K_WRITE) | (op_kind == seid_pkg::K_IDW));

	// Acceptance at the select rising edge; protection ranges by quarter.
	wire [1:0] bp  = {block_protect_high, block_protect_low};
	wire prot      = (bp == 2'h3) | ((bp == 2'h2) & addr_q[14])
		| ((bp == 2'h1) & (addr_q[14:13] == 2'h3));
	wire boundary  = in_data & (bit_q == 3'h0) & (nb_q != 2'h0);
	wire acc_arr   = (kind_q == seid_pkg::K_WRITE) & ~prot;
	wire acc_idw   = idw & ~lock_q;
	wire acc_lock  = lockcmd & (nb_q == 2'h1) & ldata_q[`SEID_LOCK_DATA_BIT]
		& (bp != 2'h3);
	wire accept    = cs_rise & wel_q & ~busy_q & boundary
		& (acc_arr | acc_idw | acc_lock);

	// Memory addressing: the commit sequencer owns the array while busy.
	wire [13:0] cm_gaddr = tid_q ? {1'b1, 9'h000, g_q} : {1'b0, tpage_q, g_q};
	wire [13:0] rd_gaddr = (kind_q == seid_pkg::K_IDR) ? {1'b1, 9'h000, addr_q[5:2]}
		: {1'b0, addr_q[14:2]};
	wire [13:0] mem_addr = busy_q ? cm_gaddr : rd_gaddr;
	wire        mem_we   = (cst_q == seid_pkg::C_ERASE) | (cst_q == seid_pkg::C_PROG);
	wire [31:0] mem_fix  = seid_pkg::ecc_fix(mem_rdata);
	wire [7:0]  rd_byte  = lockst ? {7'h00, lock_q}
		: mem_fix[{addr_q[1:0], 3'h0} +: 8];
	wire        cm_start = (cst_q == seid_pkg::C_IDLE) & go_q & ~f_ov;
	wire        tw_done  = tmr_q >= TMW'(TW_CYCLES - 1);
	wire        cyc_end  = (cst_q == seid_pkg::C_WAIT) & tw_done;
	wire [3:0]  gflags   = fl_q[{g_q, 2'h0} +: 4];
	wire [1:0]  pj       = (cst_q == seid_pkg::C_LOAD) ? 2'h0 : j_q + 2'h1;
	wire [5:0]  pb_addr  = (cst_q == seid_pkg::C_IDLE) ? fo.off : {g_q, pj};
	assign f_or      = (cst_q == seid_pkg::C_IDLE);
	assign mem_wdata = (cst_q == seid_pkg::C_ERASE) ? 38'h0
		: {seid_pkg::ecc_code(grp_q), grp_q};

	assign miso               = miso_q;
	assign miso_oe_n          = oe_n_q;
	assign write_busy_flag    = busy_q;
	assign write_enable_latch = wel_q;
	assign id_page_locked     = lock_q;

	// Two flip-flops for each pin, plus a third stage used for edge detection.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
		end
		else
		begin
			s1_q <= {mosi, cs_n, sck};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Bit counter restarted by deselection; the input shifter keeps its bits.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bit_q <= 3'h0;
			sr_q  <= 7'h00;
		end
		else if (!sel)
			bit_q <= 3'h0;
		else if (sck_rise)
		begin
			bit_q <= bit_q + 3'h1;
			sr_q  <= rx[6:0];
		end
	end

	// Command phase; unknown opcodes and every command sent while busy are skipped.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ph_q   <= seid_pkg::PH_OP;
			kind_q <= seid_pkg::K_NONE;
		end
		else if (!sel)
			ph_q <= seid_pkg::PH_OP;
		else if (byte_done)
		begin
			unique case (ph_q)
				seid_pkg::PH_OP:
				begin
					kind_q <= op_kind;
					ph_q   <= (op_kind == seid_pkg::K_NONE || busy_q)
						? seid_pkg::PH_SKIP : seid_pkg::PH_AHI;
				end
				seid_pkg::PH_AHI:  ph_q <= seid_pkg::PH_ALO;
				seid_pkg::PH_ALO:  ph_q <= seid_pkg::PH_DATA;
				seid_pkg::PH_DATA: ph_q <= seid_pkg::PH_DATA;
				seid_pkg::PH_SKIP: ph_q <= seid_pkg::PH_SKIP;
			endcase
		end
	end

	// Address capture and advance; lock status never advances.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			addr_q <= 16'h0000;
		else if (byte_done && ph_q == seid_pkg::PH_AHI)
			addr_q[15:8] <= rx;
		else if (byte_done && ph_q == seid_pkg::PH_ALO)
			addr_q[7:0] <= rx;
		else if (adv_arr)
			addr_q[14:0] <= addr_q[14:0] + 15'h0001;
		else if (adv_low)
			addr_q[5:0] <= addr_q[5:0] + 6'h01;
	end

	// Data byte count, lock data and the byte waiting for the FIFO.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			nb_q    <= 2'h0;
			ldata_q <= 8'h00;
			wp_q    <= 1'b0;
			wb_q    <= '0;
		end
		else
		begin
			if (!sel)
				nb_q <= 2'h0;
			else if (byte_done && in_data && nb_q != 2'h3)
				nb_q <= nb_q + 2'h1;
			if (byte_done && in_data && lockcmd)
				ldata_q <= rx;
			if (push)
			begin
				wp_q <= 1'b1;
				wb_q <= {addr_q[5:0], rx};
			end
			else if (f_in_ready)
				wp_q <= 1'b0;
		end
	end

	// Read pipeline: fetch two cycles after a byte ends, before the next falling clock.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_req_q  <= 1'b0;
			rd_load_q <= 1'b0;
		end
		else
		begin
			rd_req_q  <= byte_done & rd_kind & (in_data | (ph_q == seid_pkg::PH_ALO));
			rd_load_q <= rd_req_q & sel;
		end
	end

	// Output shifter: bits change on the falling serial clock.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_q   <= 8'h00;
			miso_q <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			oe_n_q <= ~(sel & in_data & rd_kind);
			if (rd_load_q)
				tx_q <= rd_byte;
			else if (sel && sck_fall)
			begin
				miso_q <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Page buffer presence flags; a new write command starts from none.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			fl_q <= 64'h0;
		else
		begin
			if (op_wr)
				fl_q <= 64'h0;
			if (f_ov && f_or)
				fl_q[fo.off] <= 1'b1;
		end
	end

	// Commit sequencer: each touched group is read, merged, erased, then programmed.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cst_q <= seid_pkg::C_IDLE;
			g_q   <= 4'h0;
			j_q   <= 2'h0;
			grp_q <= 32'h0;
			go_q  <= 1'b0;
		end
		else
		begin
			if (accept)
				go_q <= 1'b1;
			else if (cm_start)
				go_q <= 1'b0;
			unique case (cst_q)
				seid_pkg::C_IDLE:
				if (cm_start)
				begin
					g_q   <= 4'h0;
					cst_q <= tlock_q ? seid_pkg::C_WAIT : seid_pkg::C_RDG;
				end
				seid_pkg::C_RDG:
				begin
					j_q <= 2'h0;
					if (gflags != 4'h0)
						cst_q <= seid_pkg::C_LOAD;
					else
					begin
						g_q <= g_q + 4'h1;
						if (g_q == 4'hf)
							cst_q <= seid_pkg::C_WAIT;
					end
				end
				seid_pkg::C_LOAD:
				begin
					grp_q <= mem_fix;
					cst_q <= seid_pkg::C_MRG;
				end
				seid_pkg::C_MRG:
				begin
					if (fl_q[{g_q, j_q}])
						grp_q[{j_q, 3'h0} +: 8] <= pb_rdata;
					j_q <= j_q + 2'h1;
					if (j_q == 2'h3)
						cst_q <= seid_pkg::C_ERASE;
				end
				seid_pkg::C_ERASE: cst_q <= seid_pkg::C_PROG;
				seid_pkg::C_PROG:
				begin
					g_q   <= g_q + 4'h1;
					cst_q <= (g_q == 4'hf) ? seid_pkg::C_WAIT : seid_pkg::C_RDG;
				end
				seid_pkg::C_WAIT:
				if (tw_done)
					cst_q <= seid_pkg::C_IDLE;
			endcase
		end
	end

	// Busy flag, cycle timer and the target latched at acceptance.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_q  <= 1'b0;
			tmr_q   <= '0;
			tpage_q <= 9'h000;
			tid_q   <= 1'b0;
			tlock_q <= 1'b0;
		end
		else if (accept)
		begin
			busy_q  <= 1'b1;
			tmr_q   <= '0;
			tpage_q <= addr_q[14:6];
			tid_q   <= idw;
			tlock_q <= lockcmd;
		end
		else if (busy_q)
		begin
			if (!tw_done)
				tmr_q <= tmr_q + 1'b1;
			if (cyc_end)
				busy_q <= 1'b0;
		end
	end

	// Write enable latch: a set in the ending cycle wins; the lock never clears.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wel_q  <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			if (wel_set)
				wel_q <= 1'b1;
			else if (cyc_end)
				wel_q <= 1'b0;
			if (cm_start && tlock_q)
				lock_q <= 1'b1;
		end
	end

	seid_fifo #(
		.W     ($bits(seid_pkg::seid_wbyte_t)),
		.DEPTH (4)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (wp_q),
		.in_ready  (f_in_ready),
		.in_data   (wb_q),
		.out_valid (f_ov),
		.out_ready (f_or),
		.out_data  (fo)
	);

	seid_mem #(.W(8), .D(64)) u_page (
		.clk     (clk),
		.rstn    (rstn),
		.we      (f_ov & f_or),
		.addr    (pb_addr),
		.wdata   (fo.data),
		.rdata_q (pb_rdata)
	);

	seid_mem #(.W($bits(seid_pkg::seid_group_t)), .D(MD)) u_array (
		.clk     (clk),
		.rstn    (rstn),
		.we      (mem_we),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.rdata_q (mem_rdata)
	);

	// Checks on the command engine.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_read_first: assert property (rd_load_q |=> tx_q == $past(rd_byte))
		else $error("read byte not loaded");
	a_read_step: assert property (adv_arr |=> addr_q[14:0] == $past(addr_q[14:0]) + 15'h1)
		else $error("read address did not step");
	a_read_wrap: assert property (adv_arr && addr_q[14:0] == 15'h7fff |=> addr_q[14:0] == 15'h0)
		else $error("read address did not wrap");
	a_cs_stop: assert property (cs_rise |=> oe_n_q && ph_q == seid_pkg::PH_OP)
		else $error("read kept running after deselect");
	a_busy_skip: assert property (byte_done && ph_q == seid_pkg::PH_OP && busy_q
		|=> ph_q == seid_pkg::PH_SKIP)
		else $error("command taken while busy");
	a_write_start: assert property (accept |=> busy_q && go_q ##1 busy_q)
		else $error("write cycle not started");
	a_page_roll: assert property (adv_low && kind_q == seid_pkg::K_WRITE |=> addr_q[15:6]
		== $past(addr_q[15:6]) && addr_q[5:0] == $past(addr_q[5:0]) + 6'h1)
		else $error("page address left its page");
	a_wel_reject: assert property (cs_rise && !wel_q && !busy_q |=> !busy_q)
		else $error("write accepted without latch");
	a_erase_prog: assert property (cst_q == seid_pkg::C_ERASE && mem_wdata == 38'h0
		|=> cst_q == seid_pkg::C_PROG && mem_we)
		else $error("erase not followed by program");
	a_lock_byte: assert property (rd_load_q && lockst |=> tx_q == {7'h00, lock_q})
		else $error("lock status byte wrong");
	a_lock_guard: assert property (cs_rise && lockcmd && bp == 2'h3 && !busy_q |=> !busy_q)
		else $error("lock run with full protection");
	a_lock_keep: assert property (lock_q |=> lock_q)
		else $error("lock cleared");
	a_wel_clear: assert property ($fell(busy_q) |-> !wel_q || $past(wel_set))
		else $error("latch kept after write cycle");
	a_id_locked: assert property (cs_rise && idw && lock_q && !busy_q |=> !busy_q)
		else $error("locked page written");
	a_protect: assert property (cs_rise && kind_q == seid_pkg::K_WRITE && prot && !busy_q
		|=> !busy_q)
		else $error("protected page written");
endmodule

// file: verilog/seid_defs.svh
// Constants for the serial EEPROM command block: opcodes, address fields and timing.
`ifndef SEID_DEFS_SVH
`define SEID_DEFS_SVH
`define SEID_OP_READ       8'h03
`define SEID_OP_WRITE      8'h02
`define SEID_OP_RDID       8'h83
`define SEID_OP_WRID       8'h82
`define SEID_REGION_BIT    10
`define SEID_LOCK_DATA_BIT 1
`define SEID_TW_NS         5000000
`define SEID_CLK_NS        10
`define SEID_ARRAY_GROUPS  8192
`define SEID_ID_GROUPS     16
`endif

// file: verilog/seid_pkg.sv
// Types and correction-code functions shared by the serial EEPROM command block.
package seid_pkg;
	typedef enum logic [2:0] {K_NONE, K_READ, K_WRITE, K_IDR, K_IDW} seid_kind_t;
	typedef enum logic [2:0] {PH_OP, PH_AHI, PH_ALO, PH_DATA, PH_SKIP} seid_phase_t;
	typedef enum logic [2:0] {C_IDLE, C_RDG, C_LOAD, C_MRG, C_ERASE, C_PROG, C_WAIT} seid_cst_t;
	typedef struct packed {
		logic [5:0] off;
		logic [7:0] data;
	} seid_wbyte_t;
	typedef struct packed {
		logic [5:0]  code;
		logic [31:0] data;
	} seid_group_t;

	// Hamming check bits: each data bit sits at a non-power-of-two position.
	function automatic logic [5:0] ecc_code(input logic [31:0] d);
		logic [5:0] c;
		logic [5:0] p;
		c = 6'h00;
		p = 6'h02;
		for (int i = 0; i < 32; i++)
		begin
			p = p + 6'h01;
			if ((p & (p - 6'h01)) == 6'h00)
				p = p + 6'h01;
			if (d[i])
				c = c ^ p;
		end
		return c;
	endfunction

	// A syndrome naming a data position flips that bit; a check-bit error leaves data alone.
	function automatic logic [31:0] ecc_fix(input seid_group_t g);
		logic [5:0]  s;
		logic [5:0]  p;
		logic [31:0] d;
		s = g.code ^ ecc_code(g.data);
		d = g.data;
		p = 6'h02;
		for (int i = 0; i < 32; i++)
		begin
			p = p + 6'h01;
			if ((p & (p - 6'h01)) == 6'h00)
				p = p + 6'h01;
			if (p == s)
				d[i] = ~d[i];
		end
		return d;
	endfunction
endpackage

// file: verilog/seid_mem.sv
// Single-port memory with a registered read port.
`timescale 1ns/1ps
module seid_mem #(
	parameter int W  = 8,
	parameter int D  = 64,
	parameter int AW = $clog2(D)
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [W-1:0]  wdata,
	output logic      [W-1:0]  rdata_q
);
	logic [W-1:0] mem [D];

	// The array itself is not reset; it stands for nonvolatile cells.
	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	// Read data always come from a register, one cycle after the address.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_q <= '0;
		else
			rdata_q <= mem[addr];
	end
endmodule

// file: verilog/seid_fifo.sv
// Small valid/ready FIFO that carries received write bytes to the page buffer.
`timescale 1ns/1ps
module seid_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 4,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;

	// Pointers carry one extra bit so that full and empty differ.
	assign out_valid = (wp_q != rp_q);
	assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_data  = mem_q[rp_q[AW-1:0]];

	// Storage is data only and needs no reset.
	always_ff @(posedge clk)
	begin
		if (in_valid && in_ready)
			mem_q[wp_q[AW-1:0]] <= in_data;
	end

	// Pointer update on each accepted transfer.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wp_q <= wp_q + 1'b1;
			if (out_valid && out_ready)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

// file: sim/seid_host.sv
// SPI host model that shifts mode 0 frames into the command block.
`timescale 1ns/1ps
module seid_host (
	input  wire logic clk,
	output logic      sck,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe_n
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic       saw_oe;

	// The bus idles deselected with the serial clock low.
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		saw_oe = 1'b0;
	end

	// Every pin change lands just after a system clock edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Sends nbits of txq MSB first at an 80 ns serial clock; bytes after the header are gathered.
	// The output is sampled late in the high phase, since the device drives on the fall.
	task automatic frame(input int nbits);
		logic [7:0] r;
		r = 8'h00;
		rxq = {};
		saw_oe = 1'b0;
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			mosi = txq[i/8][7-i%8];
			tick(4);
			sck = 1'b1;
			tick(4);
			r = {r[6:0], miso};
			saw_oe |= !miso_oe_n;
			sck = 1'b0;
			if (i >= 24 && i % 8 == 7)
				rxq.push_back(r);
		end
		tick(4);
		cs_n = 1'b1;
		mosi = ~mosi;
		tick(4);
	endtask
endmodule

// file: sim/test_spi_eeprom_array_and_id_page_access.sv
// Self-checking bench for the serial EEPROM command block.
`timescale 1ns/1ps
`include "seid_defs.svh"
module test_spi_eeprom_array_and_id_page_access;
	logic       clk, rstn, sck, cs_n, mosi, miso, miso_oe_n, wel_set, id_page_locked;
	logic       block_protect_high, block_protect_low, write_busy_flag, write_enable_latch;
	logic       lk;
	logic [7:0] mem[int];
	logic [7:0] idp[int];
	logic [7:0] dq[$];
	int         n_mismatch, n_compared;

	seid_ctrl #(.TW_CYCLES(300)) u_seid_ctrl (.clk, .rstn, .sck, .cs_n, .mosi, .wel_set,
		.block_protect_high, .block_protect_low, .miso, .miso_oe_n, .write_busy_flag,
		.write_enable_latch, .id_page_locked);
	seid_host u_seid_host (.clk, .sck, .cs_n, .mosi, .miso, .miso_oe_n);

	// Free-running 100 MHz system clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Pulses the latch set input and confirms the latch took it.
	task automatic setwel();
		wel_set = 1'b1;
		u_seid_host.tick(1);
		wel_set = 1'b0;
		u_seid_host.tick(1);
		chk("latch", {7'h00, write_enable_latch}, 8'h01);
	endtask

	// Sends opcode, address and the bytes in dq; extra trims bits off the end.
	task automatic send(input logic [7:0] op, input logic [15:0] a, input int extra);
		u_seid_host.txq = {op, a[15:8], a[7:0], dq};
		u_seid_host.frame(8 * u_seid_host.txq.size() + extra);
	endtask

	// Waits for the timed cycle to end; a hang closes the run.
	task automatic wait_idle();
		for (int i = 0; i < 1000 && write_busy_flag !== 1'b0; i++)
			u_seid_host.tick(1);
		if (write_busy_flag !== 1'b0)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask

	// Writes n random bytes; the model rolls the offset within the page.
	// An accepted write is followed by a read that must be ignored while busy.
	task automatic wr(input logic [7:0] op, input logic [15:0] a, input int n, input bit ok,
		input int extra);
		logic [7:0] b;
		dq = {};
		for (int k = 0; k < n; k++)
		begin
			b = 8'($urandom) | {6'h00, a[10], 1'b0};
			dq.push_back(b);
			if (ok && op == `SEID_OP_WRITE)
				mem[{a[14:6], 6'(a[5:0] + k)}] = b;
			else if (ok && a[10])
				lk = 1'b1;
			else if (ok)
				idp[6'(a[5:0] + k)] = b;
		end
		send(op, a, extra);
		u_seid_host.tick(2);
		chk("busy", {7'h00, write_busy_flag}, {7'h00, ok});
		if (ok)
		begin
			dq = {8'h00};
			send(op | 8'h01, a, 0);
			chk("ignored", {7'h00, u_seid_host.saw_oe}, 8'h00);
			wait_idle();
			chk("latch", {7'h00, write_enable_latch}, 8'h00);
		end
	endtask

	// Reads n bytes from a and compares each with the model.
	task automatic rd(input logic [7:0] op, input logic [15:0] a, input int n);
		logic [7:0] e;
		dq = {};
		repeat (n) dq.push_back(8'h00);
		send(op, a, 0);
		chk("drive", {7'h00, u_seid_host.saw_oe}, 8'h01);
		chk("count", 8'(u_seid_host.rxq.size()), 8'(n));
		for (int k = 0; k < n; k++)
		begin
			e = a[10] ? {7'h00, lk} : idp[6'(a[5:0] + k)];
			if (op == `SEID_OP_READ)
				e = mem[15'(a[14:0] + k)];
			chk("read", u_seid_host.rxq[k], e);
		end
	endtask

	// Hang guard, well above the expected run time.
	initial
	begin
		#900000;
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		{rstn, wel_set, block_protect_high, block_protect_low, lk} = 5'h00;
		n_mismatch = 0;
		n_compared = 0;
		void'($urandom(54437));
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		u_seid_host.tick(4);
		chk("reset", {5'h00, write_busy_flag, write_enable_latch, id_page_locked}, 8'h00);
		wr(`SEID_OP_WRITE, 16'h003e, 3, 0, 0);
		setwel();
		wr(`SEID_OP_WRITE, 16'h003e, 3, 1, 0);
		rd(`SEID_OP_READ, 16'h003e, 2);
		rd(`SEID_OP_READ, 16'h0000, 1);
		setwel();
		wr(`SEID_OP_WRITE, 16'h7ffc, 4, 1, 0);
		rd(`SEID_OP_READ, 16'h7fff, 2);
		for (int j = 0; j < 3; j++)
		begin
			setwel();
			// Offsets stay clear of the page end, so the read never meets unwritten bytes.
			wr(`SEID_OP_WRITE, 16'($urandom) & 16'h7ff8, 1 + j, 1, 0);
			rd(`SEID_OP_READ, {u_seid_host.txq[1], u_seid_host.txq[2]}, 1 + j);
		end
		setwel();
		wr(`SEID_OP_WRITE, 16'h0200, 2, 0, -4);
		{block_protect_high, block_protect_low} = 2'b11;
		wr(`SEID_OP_WRITE, 16'h7ffc, 1, 0, 0);
		wr(`SEID_OP_WRID, 16'h0400, 1, 0, 0);
		{block_protect_high, block_protect_low} = 2'b00;
		wr(`SEID_OP_WRID, 16'h0005, 2, 1, 0);
		rd(`SEID_OP_RDID, 16'h0005, 2);
		rd(`SEID_OP_RDID, 16'h0400, 2);
		setwel();
		wr(`SEID_OP_WRID, 16'h0400, 1, 1, 0);
		chk("locked", {7'h00, id_page_locked}, 8'h01);
		rd(`SEID_OP_RDID, 16'h0400, 3);
		setwel();
		wr(`SEID_OP_WRID, 16'h0006, 1, 0, 0);
		rd(`SEID_OP_RDID, 16'h0005, 2);
		// A read cut off in mid-byte must have driven and then release the output at once.
		dq = {8'h00};
		send(`SEID_OP_READ, 16'h003e, -3);
		chk("cut_drive", {7'h00, u_seid_host.saw_oe}, 8'h01);
		chk("cut_release", {7'h00, miso_oe_n}, 8'h01);
		chk("cut_idle", {7'h00, write_busy_flag}, 8'h00);
		tally_and_finish();
	end
endmodule
